// [hw/apb_master_engine.sv]
// apb master that runs one setup/access transfer per start pulse
`timescale 1ns/1ns
module apb_master_engine (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request side
    input  wire logic        start,
    input  wire logic        write,
    input  wire logic [15:0] addr,
    input  wire logic [31:0] wdata,
    output      logic        busy,
    output      logic        done,
    output      logic [31:0] rdata,
    // apb side
    output      logic        psel,
    output      logic        penable,
    output      logic        pwrite,
    output      logic [15:0] paddr,
    output      logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);

    typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACCESS} apb_phase_t;

    apb_phase_t  phase_r;
    apb_phase_t  phase_nxt;
    logic        psel_r,    psel_nxt;
    logic        penable_r, penable_nxt;
    logic        pwrite_r,  pwrite_nxt;
    logic [15:0] paddr_r,   paddr_nxt;
    logic [31:0] pwdata_r,  pwdata_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic        done_r,    done_nxt;

    always_comb begin
        phase_nxt   = phase_r;
        psel_nxt    = psel_r;
        penable_nxt = penable_r;
        pwrite_nxt  = pwrite_r;
        paddr_nxt   = paddr_r;
        pwdata_nxt  = pwdata_r;
        rdata_nxt   = rdata_r;
        done_nxt    = 1'b0;
        unique case (phase_r)
            PH_IDLE: begin
                // address and data are latched so software may edit its copies meanwhile
                if (start) begin
                    psel_nxt   = 1'b1;
                    pwrite_nxt = write;
                    paddr_nxt  = addr;
                    pwdata_nxt = wdata;
                    phase_nxt  = PH_SETUP;
                end
            end
            PH_SETUP: begin
                penable_nxt = 1'b1;
                phase_nxt   = PH_ACCESS;
            end
            PH_ACCESS: begin
                if (pready) begin
                    psel_nxt    = 1'b0;
                    penable_nxt = 1'b0;
                    done_nxt    = 1'b1;
                    phase_nxt   = PH_IDLE;
                    if (!pwrite_r) begin
                        rdata_nxt = prdata;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r   <= PH_IDLE;
            psel_r    <= 1'b0;
            penable_r <= 1'b0;
            pwrite_r  <= 1'b0;
            paddr_r   <= bridge_pkg::RST_ADDR;
            pwdata_r  <= bridge_pkg::RST_WORD;
            rdata_r   <= bridge_pkg::RST_WORD;
            done_r    <= 1'b0;
        end else begin
            phase_r   <= phase_nxt;
            psel_r    <= psel_nxt;
            penable_r <= penable_nxt;
            pwrite_r  <= pwrite_nxt;
            paddr_r   <= paddr_nxt;
            pwdata_r  <= pwdata_nxt;
            rdata_r   <= rdata_nxt;
            done_r    <= done_nxt;
        end
    end

    // busy covers the done cycle so the owner cannot relaunch before it has seen done
    assign busy    = (phase_r != PH_IDLE) || done_r;
    assign done    = done_r;
    assign rdata   = rdata_r;
    assign psel    = psel_r;
    assign penable = penable_r;
    assign pwrite  = pwrite_r;
    assign paddr   = paddr_r;
    assign pwdata  = pwdata_r;

endmodule : apb_master_engine

// [hw/bridge_pkg.sv]
// constants for the indirect register access bridge
package bridge_pkg;

    // register offsets
    localparam logic [7:0]  OFS_ANA_CTRL     = 8'h40;
    localparam logic [7:0]  OFS_ANA_OFFSET   = 8'h41;
    localparam logic [7:0]  OFS_ANA_VALUE    = 8'h42;
    localparam logic [7:0]  OFS_APB_CTRL     = 8'h48;
    localparam logic [7:0]  OFS_APB_ADDR_LO  = 8'h49;
    localparam logic [7:0]  OFS_APB_ADDR_HI  = 8'h4A;
    localparam logic [7:0]  OFS_APB_BYTE0    = 8'h4B;
    localparam logic [7:0]  OFS_APB_BYTE1    = 8'h4C;
    localparam logic [7:0]  OFS_APB_BYTE2    = 8'h4D;
    localparam logic [7:0]  OFS_APB_BYTE3    = 8'h4E;

    // analog control fields
    localparam int          ANA_DIR_BIT      = 0;
    localparam int          ANA_INC_BIT      = 1;
    localparam int          ANA_SEL_LSB      = 2;
    localparam int          ANA_SEL_MSB      = 4;
    localparam logic [7:0]  ANA_CTRL_MASK    = 8'h1F;

    // analog target codes
    localparam logic [2:0]  ANA_SEL_OFF      = 3'h0;
    localparam logic [2:0]  ANA_SEL_VIDEO_RX = 3'h4;
    localparam logic [2:0]  ANA_SEL_SER_TX   = 3'h5;
    localparam logic [7:0]  ANA_STEP         = 8'h01;

    // apb control fields
    localparam int          APB_EN_BIT       = 0;
    localparam int          APB_RD_BIT       = 1;
    localparam int          APB_INC_BIT      = 2;
    localparam int          APB_SEL_LSB      = 3;
    localparam int          APB_SEL_MSB      = 4;
    localparam logic [7:0]  APB_CTRL_MASK    = 8'h1F;

    // apb target codes
    localparam logic [1:0]  APB_TGT_VIDEO_RX = 2'h0;
    localparam logic [1:0]  APB_TGT_DISP_ID  = 2'h1;
    localparam logic [1:0]  APB_TGT_CONFIG   = 2'h2;
    localparam logic [1:0]  APB_TGT_DIE_ID   = 2'h3;
    localparam logic [15:0] APB_STEP_VIDEO   = 16'h0004;
    localparam logic [15:0] APB_STEP_OTHER   = 16'h0001;

    // reset values
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [15:0] RST_ADDR         = 16'h0000;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;

endpackage : bridge_pkg

// [hw/indirect_register_access_bridge.sv]
// register window onto the analog port and the apb master
`timescale 1ns/1ns
module indirect_register_access_bridge (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // serial control bus register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_WDATA,
    output      logic [7:0]  REG_RDATA,
    output      logic        REG_ACK,
    output      logic        REG_BUSY,
    // analog indirect port
    output      logic        ANA_REQ,
    output      logic        ANA_WRITE,
    output      logic [2:0]  ANA_TARGET,
    output      logic [7:0]  ANA_OFFSET,
    output      logic [7:0]  ANA_WDATA,
    input  wire logic [7:0]  ANA_RDATA,
    input  wire logic        ANA_ACK,
    // apb master
    output      logic        PSEL,
    output      logic        PENABLE,
    output      logic        PWRITE,
    output      logic [15:0] PADDR,
    output      logic [31:0] PWDATA,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    output      logic [1:0]  APB_TARGET
);

    typedef enum logic {ST_IDLE, ST_ANA} port_state_t;

    port_state_t state_r;
    port_state_t state_nxt;

    // register file
    logic [7:0]  ana_ctrl_r,   ana_ctrl_nxt;
    logic [7:0]  ana_offset_r, ana_offset_nxt;
    logic [7:0]  ana_value_r,  ana_value_nxt;
    logic [7:0]  apb_ctrl_r,   apb_ctrl_nxt;
    logic [15:0] apb_addr_r,   apb_addr_nxt;
    logic [31:0] apb_word_r,   apb_word_nxt;

    // transfer bookkeeping
    logic        ana_req_r,    ana_req_nxt;
    logic        ana_write_r,  ana_write_nxt;
    logic [2:0]  ana_tgt_r,    ana_tgt_nxt;
    logic        wr_pend_r,    wr_pend_nxt;
    logic        op_read_r,    op_read_nxt;
    logic [1:0]  apb_tgt_r,    apb_tgt_nxt;
    logic [7:0]  rdata_r,      rdata_nxt;
    logic        ack_r,        ack_nxt;

    // decoded fields and engine wires
    logic [2:0]  ana_sel;
    logic        ana_valid;
    logic [1:0]  apb_sel;
    logic        apb_en;
    logic        apb_writable;
    logic [15:0] apb_step;
    logic        eng_start;
    logic        eng_write;
    logic        eng_busy;
    logic        eng_done;
    logic [31:0] eng_rdata;

    assign ana_sel = ana_ctrl_r[bridge_pkg::ANA_SEL_MSB:bridge_pkg::ANA_SEL_LSB];
    assign ana_valid = (ana_sel == bridge_pkg::ANA_SEL_VIDEO_RX) ||
                       (ana_sel == bridge_pkg::ANA_SEL_SER_TX);
    assign apb_sel = apb_ctrl_r[bridge_pkg::APB_SEL_MSB:bridge_pkg::APB_SEL_LSB];
    assign apb_en  = apb_ctrl_r[bridge_pkg::APB_EN_BIT];
    // config data and die id cannot be written
    assign apb_writable = (apb_sel == bridge_pkg::APB_TGT_VIDEO_RX) ||
                          (apb_sel == bridge_pkg::APB_TGT_DISP_ID);
    // step follows the target of the finished transfer, not the current select
    assign apb_step = (apb_tgt_r == bridge_pkg::APB_TGT_VIDEO_RX) ?
                      bridge_pkg::APB_STEP_VIDEO : bridge_pkg::APB_STEP_OTHER;

    always_comb begin
        state_nxt      = state_r;
        ana_ctrl_nxt   = ana_ctrl_r;
        ana_offset_nxt = ana_offset_r;
        ana_value_nxt  = ana_value_r;
        apb_ctrl_nxt   = apb_ctrl_r;
        apb_addr_nxt   = apb_addr_r;
        apb_word_nxt   = apb_word_r;
        ana_req_nxt    = ana_req_r;
        ana_write_nxt  = ana_write_r;
        ana_tgt_nxt    = ana_tgt_r;
        wr_pend_nxt    = wr_pend_r;
        op_read_nxt    = op_read_r;
        apb_tgt_nxt    = apb_tgt_r;
        rdata_nxt      = rdata_r;
        ack_nxt        = 1'b0;
        eng_start      = 1'b0;
        eng_write      = 1'b0;

        // apb completion: a read loads the word and drops read-start; the address steps only with increment set
        if (eng_done) begin
            if (op_read_r) begin
                apb_word_nxt = eng_rdata;
                apb_ctrl_nxt[bridge_pkg::APB_RD_BIT] = 1'b0;
            end
            if (apb_ctrl_r[bridge_pkg::APB_INC_BIT]) begin
                apb_addr_nxt = apb_addr_r + apb_step;
            end
        end

        // apb launch; a pending write goes ahead of a read-start
        if (!eng_busy && apb_en) begin
            if (wr_pend_r) begin
                eng_start   = 1'b1;
                eng_write   = 1'b1;
                wr_pend_nxt = 1'b0;
                op_read_nxt = 1'b0;
                apb_tgt_nxt = apb_sel;
            end else if (apb_ctrl_r[bridge_pkg::APB_RD_BIT]) begin
                eng_start   = 1'b1;
                op_read_nxt = 1'b1;
                apb_tgt_nxt = apb_sel;
            end
        end

        unique case (state_r)
            ST_IDLE: begin
                if (REG_WR) begin
                    ack_nxt = 1'b1;
                    unique case (REG_ADDR)
                        bridge_pkg::OFS_ANA_CTRL: begin
                            ana_ctrl_nxt = REG_WDATA & bridge_pkg::ANA_CTRL_MASK;
                        end
                        bridge_pkg::OFS_ANA_OFFSET: begin
                            ana_offset_nxt = REG_WDATA;
                        end
                        bridge_pkg::OFS_ANA_VALUE: begin
                            ana_value_nxt = REG_WDATA;
                            // in read direction the byte is only kept locally
                            if (ana_valid && !ana_ctrl_r[bridge_pkg::ANA_DIR_BIT]) begin
                                ack_nxt       = 1'b0;
                                ana_req_nxt   = 1'b1;
                                ana_write_nxt = 1'b1;
                                ana_tgt_nxt   = ana_sel;
                                state_nxt     = ST_ANA;
                            end
                        end
                        bridge_pkg::OFS_APB_CTRL: begin
                            // software write lands after the hardware clear, so a set wins
                            apb_ctrl_nxt = REG_WDATA & bridge_pkg::APB_CTRL_MASK;
                        end
                        bridge_pkg::OFS_APB_ADDR_LO: begin
                            apb_addr_nxt[7:0] = REG_WDATA;
                        end
                        bridge_pkg::OFS_APB_ADDR_HI: begin
                            apb_addr_nxt[15:8] = REG_WDATA;
                        end
                        bridge_pkg::OFS_APB_BYTE0: begin
                            apb_word_nxt[7:0] = REG_WDATA;
                        end
                        bridge_pkg::OFS_APB_BYTE1: begin
                            apb_word_nxt[15:8] = REG_WDATA;
                        end
                        bridge_pkg::OFS_APB_BYTE2: begin
                            apb_word_nxt[23:16] = REG_WDATA;
                        end
                        bridge_pkg::OFS_APB_BYTE3: begin
                            apb_word_nxt[31:24] = REG_WDATA;
                            if (apb_en && apb_writable) begin
                                wr_pend_nxt = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (REG_RD) begin
                    ack_nxt = 1'b1;
                    unique case (REG_ADDR)
                        bridge_pkg::OFS_ANA_CTRL:    rdata_nxt = ana_ctrl_r;
                        bridge_pkg::OFS_ANA_OFFSET:  rdata_nxt = ana_offset_r;
                        bridge_pkg::OFS_ANA_VALUE: begin
                            rdata_nxt = bridge_pkg::RST_BYTE;
                            if (ana_valid) begin
                                ack_nxt       = 1'b0;
                                ana_req_nxt   = 1'b1;
                                ana_write_nxt = 1'b0;
                                ana_tgt_nxt   = ana_sel;
                                state_nxt     = ST_ANA;
                            end
                        end
                        bridge_pkg::OFS_APB_CTRL:    rdata_nxt = apb_ctrl_r;
                        bridge_pkg::OFS_APB_ADDR_LO: rdata_nxt = apb_addr_r[7:0];
                        bridge_pkg::OFS_APB_ADDR_HI: rdata_nxt = apb_addr_r[15:8];
                        bridge_pkg::OFS_APB_BYTE0:   rdata_nxt = apb_word_r[7:0];
                        bridge_pkg::OFS_APB_BYTE1:   rdata_nxt = apb_word_r[15:8];
                        bridge_pkg::OFS_APB_BYTE2:   rdata_nxt = apb_word_r[23:16];
                        bridge_pkg::OFS_APB_BYTE3:   rdata_nxt = apb_word_r[31:24];
                        default:                     rdata_nxt = bridge_pkg::RST_BYTE;
                    endcase
                end
            end
            ST_ANA: begin
                // register port requests are ignored here; REG_BUSY tells software
                if (ANA_ACK) begin
                    ana_req_nxt = 1'b0;
                    ack_nxt     = 1'b1;
                    state_nxt   = ST_IDLE;
                    if (!ana_write_r) begin
                        ana_value_nxt = ANA_RDATA;
                        rdata_nxt     = ANA_RDATA;
                    end
                    if (ana_ctrl_r[bridge_pkg::ANA_INC_BIT]) begin
                        ana_offset_nxt = ana_offset_r + bridge_pkg::ANA_STEP;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r      <= ST_IDLE;
            ana_ctrl_r   <= bridge_pkg::RST_BYTE;
            ana_offset_r <= bridge_pkg::RST_BYTE;
            ana_value_r  <= bridge_pkg::RST_BYTE;
            apb_ctrl_r   <= bridge_pkg::RST_BYTE;
            apb_addr_r   <= bridge_pkg::RST_ADDR;
            apb_word_r   <= bridge_pkg::RST_WORD;
            ana_req_r    <= 1'b0;
            ana_write_r  <= 1'b0;
            ana_tgt_r    <= bridge_pkg::ANA_SEL_OFF;
            wr_pend_r    <= 1'b0;
            op_read_r    <= 1'b0;
            apb_tgt_r    <= bridge_pkg::APB_TGT_VIDEO_RX;
            rdata_r      <= bridge_pkg::RST_BYTE;
            ack_r        <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            ana_ctrl_r   <= ana_ctrl_nxt;
            ana_offset_r <= ana_offset_nxt;
            ana_value_r  <= ana_value_nxt;
            apb_ctrl_r   <= apb_ctrl_nxt;
            apb_addr_r   <= apb_addr_nxt;
            apb_word_r   <= apb_word_nxt;
            ana_req_r    <= ana_req_nxt;
            ana_write_r  <= ana_write_nxt;
            ana_tgt_r    <= ana_tgt_nxt;
            wr_pend_r    <= wr_pend_nxt;
            op_read_r    <= op_read_nxt;
            apb_tgt_r    <= apb_tgt_nxt;
            rdata_r      <= rdata_nxt;
            ack_r        <= ack_nxt;
        end
    end

    apb_master_engine u_apb (
        .clk     (CLK),
        .rst     (SYS_RST),
        .start   (eng_start),
        .write   (eng_write),
        .addr    (apb_addr_r),
        .wdata   (apb_word_r),
        .busy    (eng_busy),
        .done    (eng_done),
        .rdata   (eng_rdata),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .prdata  (PRDATA),
        .pready  (PREADY)
    );

    assign REG_RDATA  = rdata_r;
    assign REG_ACK    = ack_r;
    assign REG_BUSY   = (state_r != ST_IDLE);
    assign ANA_REQ    = ana_req_r;
    assign ANA_WRITE  = ana_write_r;
    assign ANA_TARGET = ana_tgt_r;
    // offset and value are frozen during a transfer since the port is not served then
    assign ANA_OFFSET = ana_offset_r;
    assign ANA_WDATA  = ana_value_r;
    assign APB_TARGET = apb_tgt_r;

endmodule : indirect_register_access_bridge

// [verification/bridge_assertions.sv]
// concurrent checks on the bridge top-level ports
`timescale 1ns/1ns
module bridge_assertions (
    // clock and reset
    input wire logic        CLK,
    input wire logic        SYS_RST,
    // register port
    input wire logic [7:0]  REG_ADDR,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        REG_ACK,
    input wire logic        REG_BUSY,
    // analog port
    input wire logic        ANA_REQ,
    input wire logic        ANA_WRITE,
    input wire logic [2:0]  ANA_TARGET,
    input wire logic [7:0]  ANA_OFFSET,
    input wire logic [7:0]  ANA_RDATA,
    input wire logic        ANA_ACK,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic        PREADY,
    input wire logic [1:0]  APB_TARGET
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_ana_target;
        ANA_REQ |-> ANA_TARGET inside {3'h4, 3'h5};
    endproperty
    a_ana_target: assert property (p_ana_target) else $error("analog target bad");
    property p_ana_hold;
        ANA_REQ && !ANA_ACK |=> ANA_REQ && $stable(ANA_OFFSET) && $stable(ANA_WRITE);
    endproperty
    a_ana_hold: assert property (p_ana_hold) else $error("analog request moved");
    property p_ana_done;
        ANA_REQ && ANA_ACK |=> !ANA_REQ && REG_ACK;
    endproperty
    a_ana_done: assert property (p_ana_done) else $error("analog end wrong");
    property p_ana_rdata;
        ANA_REQ && ANA_ACK && !ANA_WRITE |=> REG_RDATA == $past(ANA_RDATA);
    endproperty
    a_ana_rdata: assert property (p_ana_rdata) else $error("analog read data lost");
    property p_reg_ack;
        (REG_WR || REG_RD) && !REG_BUSY && REG_ADDR != 8'h42 |=> REG_ACK;
    endproperty
    a_reg_ack: assert property (p_reg_ack) else $error("register access not acked");
    property p_apb_setup;
        $rose(PSEL) |-> !PENABLE ##1 PSEL && PENABLE;
    endproperty
    a_apb_setup: assert property (p_apb_setup) else $error("apb phase order");
    property p_apb_stable;
        PSEL && !(PENABLE && PREADY) |=> PSEL && $stable(PADDR) && $stable(PWRITE);
    endproperty
    a_apb_stable: assert property (p_apb_stable) else $error("apb request moved");
    property p_apb_end;
        PSEL && PENABLE && PREADY |=> !PSEL && !PENABLE;
    endproperty
    a_apb_end: assert property (p_apb_end) else $error("apb transfer not ended");
    property p_apb_ro;
        PSEL && PWRITE |-> !APB_TARGET[1];
    endproperty
    a_apb_ro: assert property (p_apb_ro) else $error("write to read-only target");
endmodule : bridge_assertions
bind indirect_register_access_bridge bridge_assertions u_bridge_assertions (
    .CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_BUSY(REG_BUSY), .ANA_REQ(ANA_REQ),
    .ANA_WRITE(ANA_WRITE), .ANA_TARGET(ANA_TARGET), .ANA_OFFSET(ANA_OFFSET),
    .ANA_RDATA(ANA_RDATA), .ANA_ACK(ANA_ACK), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .APB_TARGET(APB_TARGET));

// [verification/bridge_partner.sv]
// far-side model: analog register blocks and apb targets
`timescale 1ns/1ns
module bridge_partner (
    // clock and stall control
    input wire logic        clk,
    input wire logic        slow,
    // analog port
    input wire logic        ana_req,
    input wire logic        ana_write,
    input wire logic [2:0]  ana_target,
    input wire logic [7:0]  ana_offset,
    input wire logic [7:0]  ana_wdata,
    output     logic [7:0]  ana_rdata,
    output     logic        ana_ack,
    // apb target side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [1:0]  apb_target,
    output     logic [31:0] prdata,
    output     logic        pready
);
    logic [7:0]  ana_mem [0:511];
    logic [31:0] apb_mem [0:255];
    logic [7:0]  ana_q;
    logic [31:0] apb_q;
    logic [1:0]  ana_w, apb_w, lim;
    initial begin
        ana_ack = 1'b0;
        ana_q = 8'h00;
        apb_q = 32'h0;
        ana_w = 2'h0;
        apb_w = 2'h0;
        for (int i = 0; i < 512; i++) ana_mem[i] = 8'(i) ^ 8'h3C;
        for (int i = 0; i < 256; i++) apb_mem[i] = {8'hC3, 8'(i), 8'h5A, ~8'(i)};
    end
    assign lim = slow ? 2'h3 : 2'h0;
    // idle return lines show the inverse of the last value so stale data cannot pass
    assign ana_rdata = ana_ack ? ana_q : ~ana_q;
    assign pready = psel && penable && apb_w == lim;
    assign prdata = pready ? apb_mem[{apb_target, paddr[5:0] ^ paddr[13:8]}] : ~apb_q;
    always @(posedge clk) begin
        ana_ack <= 1'b0;
        if (ana_req && !ana_ack) begin
            ana_w <= ana_w + 2'h1;
            if (ana_w == lim) begin
                ana_w <= 2'h0;
                ana_ack <= 1'b1;
                if (ana_write) ana_mem[{ana_target[0], ana_offset}] <= ana_wdata;
                else ana_q <= ana_mem[{ana_target[0], ana_offset}];
            end
        end
        apb_w <= (psel && penable && !pready) ? apb_w + 2'h1 : 2'h0;
        if (pready) begin
            apb_q <= prdata;
            if (pwrite) apb_mem[{apb_target, paddr[5:0] ^ paddr[13:8]}] <= pwdata;
        end
    end
endmodule : bridge_partner

// [verification/testbench.sv]
// self-checking bench for the indirect register access bridge
`timescale 1ns/1ns
module testbench;
    logic        CLK, SYS_RST, REG_WR, REG_RD, REG_ACK, REG_BUSY, slow;
    logic        ANA_REQ, ANA_WRITE, ANA_ACK, PSEL, PENABLE, PWRITE, PREADY;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, ANA_OFFSET, ANA_WDATA, ANA_RDATA;
    logic [2:0]  ANA_TARGET;
    logic [1:0]  APB_TARGET;
    logic [15:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    int          fails, checked, cyc, ana_n, xfers;
    indirect_register_access_bridge u_indirect_register_access_bridge (
        .CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_BUSY(REG_BUSY),
        .ANA_REQ(ANA_REQ), .ANA_WRITE(ANA_WRITE), .ANA_TARGET(ANA_TARGET),
        .ANA_OFFSET(ANA_OFFSET), .ANA_WDATA(ANA_WDATA), .ANA_RDATA(ANA_RDATA),
        .ANA_ACK(ANA_ACK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .APB_TARGET(APB_TARGET));
    bridge_partner u_bridge_partner (
        .clk(CLK), .slow(slow), .ana_req(ANA_REQ), .ana_write(ANA_WRITE),
        .ana_target(ANA_TARGET), .ana_offset(ANA_OFFSET), .ana_wdata(ANA_WDATA),
        .ana_rdata(ANA_RDATA), .ana_ack(ANA_ACK), .psel(PSEL), .penable(PENABLE),
        .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA), .apb_target(APB_TARGET),
        .prdata(PRDATA), .pready(PREADY));
    task automatic stop_test();
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // one request, then wait for its acknowledge; never issued while busy
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge CLK);
        REG_WR <= w;
        REG_RD <= !w;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
        do begin
            @(posedge CLK);
            n++;
        end while (REG_ACK !== 1'b1 && n < 40);
        chk(REG_ACK, 1'b1);
        q = REG_RDATA;
    endtask : acc
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    task automatic rdx(input logic [7:0] a, e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rdx
    task automatic wait_x(input int n);
        for (int i = 0; i < 20 && xfers == n; i++) @(posedge CLK);
    endtask : wait_x
    task automatic wait_rd();
        logic [7:0] q;
        q = 8'h02;
        for (int n = 0; n < 20 && q[1]; n++) acc(1'b0, 8'h48, 8'h00, q);
        chk(q[1], 1'b0);
    endtask : wait_rd
    task automatic t_reset();
        wr(8'h45, 8'hFF);
        for (int i = 8'h40; i <= 8'h50; i++) rdx(8'(i), 8'h00);
    endtask : t_reset
    task automatic t_analog();
        wr(8'h40, 8'h12);
        wr(8'h41, 8'h7F);
        wr(8'h42, 8'hAB);
        rdx(8'h41, 8'h80);
        slow <= 1'b1;
        wr(8'h40, 8'h13);
        wr(8'h41, 8'h7F);
        rdx(8'h42, 8'hAB);
        wr(8'h40, 8'h15);
        wr(8'h41, 8'h7F);
        rdx(8'h42, 8'h43);
        rdx(8'h41, 8'h7F);
        rdx(8'h40, 8'h15);
        chk(ana_n, 3);
        slow <= 1'b0;
    endtask : t_analog
    task automatic t_reserved();
        int n;
        for (int s = 0; s < 8; s++) if (s != 4 && s != 5) begin
            n = ana_n;
            wr(8'h40, 8'(s << 2));
            wr(8'h42, 8'h55);
            rdx(8'h42, 8'h00);
            chk(ana_n, n);
        end
    endtask : t_reserved
    task automatic t_apb_read();
        wr(8'h49, 8'h10);
        wr(8'h4A, 8'h00);
        wr(8'h48, 8'h1F);
        wait_rd();
        rdx(8'h4B, 8'h2F);
        rdx(8'h4C, 8'h5A);
        rdx(8'h4D, 8'hD0);
        rdx(8'h4E, 8'hC3);
        rdx(8'h49, 8'h11);
        slow <= 1'b1;
        wr(8'h49, 8'h00);
        wr(8'h4A, 8'h01);
        wr(8'h48, 8'h07);
        wait_rd();
        rdx(8'h4B, 8'hFE);
        rdx(8'h49, 8'h04);
        rdx(8'h4A, 8'h01);
        slow <= 1'b0;
    endtask : t_apb_read
    task automatic t_apb_write();
        int n;
        wr(8'h48, 8'h09);
        wr(8'h49, 8'h20);
        wr(8'h4A, 8'h00);
        wr(8'h4B, 8'h11);
        wr(8'h4C, 8'h22);
        wr(8'h4D, 8'h33);
        n = xfers;
        wr(8'h4E, 8'h44);
        wait_x(n);
        chk(xfers, n + 1);
        wr(8'h48, 8'h08);
        for (int i = 8'h4B; i <= 8'h4E; i++) wr(8'(i), 8'h00);
        wr(8'h48, 8'h0B);
        wait_rd();
        for (int i = 0; i < 4; i++) rdx(8'h4B + 8'(i), 8'h11 * 8'(i + 1));
        n = xfers;
        wr(8'h48, 8'h0A);
        wait_x(n);
        rdx(8'h48, 8'h0A);
        wr(8'h48, 8'h19);
        wr(8'h4E, 8'h77);
        wait_x(n);
        chk(xfers, n);
        wr(8'h48, 8'h00);
    endtask : t_apb_write
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (ANA_REQ && ANA_ACK) ana_n++;
        if (PSEL && PENABLE && PREADY) xfers++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        SYS_RST = 1'b1;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        slow = 1'b0;
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_analog();
        t_reserved();
        t_apb_read();
        t_apb_write();
        stop_test();
    end
endmodule : testbench
